// [hlb_pkg.sv]
package hlb_pkg;
   localparam int ADDR_W = 22;
   localparam int DATA_W = 16;
   localparam real CLK_PERIOD_NS = 10.0;
   localparam real CLK_DUTY_PCT = 50.0;
   localparam int MEM_DEPTH = 16;
   localparam int MEM_IDX_LSB = 1;
   localparam logic [ADDR_W-1:0] IRQ_REG_ADDR = 22'h3FFFFE;
   localparam logic PHASE_ONE = 1'b1;
   localparam logic UBE_MASTER_LEVEL = 1'b0;
   localparam logic MIO_MASTER_LEVEL = 1'b1;
   localparam logic STRAP_SYNC_LEVEL = 1'b1;
   localparam logic STRAP_CMD_LEVEL = 1'b0;
   localparam int SMP_RD = 0;
   localparam int SMP_WR = 1;
   localparam int SMP_GNT = 2;
   localparam int SMP_W = 3;

   typedef struct packed {
      logic syncStrobes;
      logic cmdProtocol;
      logic [1:0] testMode;
   } hlb_strap_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic write;
   } hlb_mreq_t;

   typedef enum {
      M_IDLE,
      M_REQ,
      M_CYCLE,
      M_WAIT,
      M_RELEASE
   } hlb_mstate_t;
endpackage

// [host_local_bus_interface.sv]
// Notes on behaviour
// RULE1 - address lines are inputs as slave, driven only while owning the bus
// RULE2 - upper byte enable is a slave input, driven low while master
// RULE3 - upper byte enable at reset end picks synchronous or asynchronous sampling
// RULE4 - strobes are slave inputs sampled per strap, driven by us as master
// RULE5 - memory/io pin is a slave input, driven high while master
// RULE6 - memory/io pin at reset end picks command or status-only protocol
// RULE7 - slave access only while chip select is low
// RULE8 - master path enable high exactly while we own the bus after grant
// RULE9 - slave path enable high while a slave cycle runs
// RULE10 - ready input sampled synchronously during our master cycles
// RULE11 - hold request high while an engine needs the bus
// RULE12 - grant comes only in answer to our hold request
// RULE13 - interrupt is OR of engine interrupts, cleared by interrupt register access
// RULE14 - reset synchronised inside, all units to defined state; the memory array mem_q has no reset
// RULE15 - reset aligns the two-phase divider to phase one
// RULE16 - strobe levels at reset end latched as test mode
// RULE17 - internal cycle is two input clock periods
// RULE18 - slave path reads and writes graphics memory
// RULE19 - no master drive before grant, drive released before request drops
`timescale 1ns/10ps
module host_local_bus_interface #(
   parameter int MemDepth = hlb_pkg::MEM_DEPTH
) (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [hlb_pkg::ADDR_W-1:0] localAddrIn,
   output logic [hlb_pkg::ADDR_W-1:0] localAddrOut,
   output logic localAddrOe,
   input wire logic [hlb_pkg::DATA_W-1:0] localDataIn,
   output logic [hlb_pkg::DATA_W-1:0] localDataOut,
   output logic localDataOe,
   input wire logic upperByteEnableNIn,
   output logic upperByteEnableNOut,
   output logic upperByteEnableNOe,
   input wire logic rdNIn,
   output logic rdNOut,
   output logic rdNOe,
   input wire logic wrNIn,
   output logic wrNOut,
   output logic wrNOe,
   input wire logic memIoSelectIn,
   output logic memIoSelectOut,
   output logic memIoSelectOe,
   input wire logic csN,
   input wire logic readyN,
   input wire logic busHoldGrant,
   output logic busHoldRequest,
   output logic masterPathEnable,
   output logic slavePathEnable,
   input wire logic drawIrq,
   input wire logic dispIrq,
   output logic irqOut,
   output logic phaseOne,
   output hlb_pkg::hlb_strap_t strapOut,
   input wire logic engineNeedBus,
   input wire hlb_pkg::hlb_mreq_t engineReq,
   output logic engineDone,
   output logic [hlb_pkg::DATA_W-1:0] engineRdata
);
   import hlb_pkg::*;

   localparam int IdxW = $clog2(MemDepth);

   function automatic logic [IdxW-1:0] memIndex(input logic [ADDR_W-1:0] a);
      memIndex = a[MEM_IDX_LSB +: IdxW];
   endfunction

   logic rstMeta_q, rstSync_q, rstDone_q;
   logic phase_q;
   hlb_strap_t strap_q;
   logic [SMP_W-1:0] smpMeta_q, smpSync_q, smpDirect_q;
   logic csN_q, mio_q;
   logic [ADDR_W-1:0] addrIn_q;
   logic [DATA_W-1:0] dataIn_q;
   logic [DATA_W-1:0] mem_q [MemDepth];
   hlb_mstate_t state_q, state_d;
   hlb_mreq_t mreq_q;
   logic holdReq_q, masterEn_q, busOe_q, rdStrobeN_q, wrStrobeN_q;
   logic slaveEn_q, dataOe_q;
   logic [DATA_W-1:0] dataOut_q, engRdata_q;
   logic engDone_q, irq_q, drawPrev_q, dispPrev_q;

   wire inRst = !rstSync_q;
   wire cycleEn = phase_q;
   wire [SMP_W-1:0] smpSel = strap_q.syncStrobes ? smpDirect_q : smpSync_q; // RULE3
   wire rdAct = !smpSel[SMP_RD]; // RULE4
   wire wrAct = !smpSel[SMP_WR]; // RULE4
   wire grantS = smpSel[SMP_GNT];
   wire slaveHit = !csN_q && (rdAct || wrAct) && !masterEn_q && !inRst; // RULE7 RULE14
   wire slaveStart = slaveHit && !slaveEn_q;
   wire regSpace = strap_q.cmdProtocol ? !mio_q : 1'b1; // RULE6
   wire isIrqReg = regSpace && (addrIn_q == IRQ_REG_ADDR);
   wire irqClr = slaveStart && isIrqReg; // RULE13
   wire irqEvt = (drawIrq && !drawPrev_q) || (dispIrq && !dispPrev_q); // RULE13
   wire memWr = slaveStart && wrAct && !isIrqReg; // RULE18
   wire [DATA_W-1:0] irqWord = {{(DATA_W-1){1'b0}}, irq_q};
   wire [DATA_W-1:0] slaveRd = isIrqReg ? irqWord : mem_q[memIndex(addrIn_q)]; // RULE18
   wire readyS = !readyN; // RULE10

   // reset release is synchronised so the divider, master state and slave/interrupt logic leave reset on one edge
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1; // RULE14
         rstSync_q <= rstMeta_q; // RULE14
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         phase_q <= PHASE_ONE;
         rstDone_q <= 1'b0;
         strap_q <= '0;
      end else begin
         phase_q <= inRst ? PHASE_ONE : !phase_q; // RULE15 RULE17
         rstDone_q <= rstSync_q;
         // straps caught by a clock edge at release, never by the reset itself
         if (rstSync_q && !rstDone_q) begin
            strap_q.syncStrobes <= (upperByteEnableNIn == STRAP_SYNC_LEVEL); // RULE3
            strap_q.cmdProtocol <= (memIoSelectIn == STRAP_CMD_LEVEL); // RULE6
            strap_q.testMode <= {rdNIn, wrNIn}; // RULE16
         end
      end
   end

   // one flop for synchronous masters, two flops for asynchronous ones
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         smpMeta_q <= 3'h3;
         smpSync_q <= 3'h3;
         smpDirect_q <= 3'h3;
         csN_q <= 1'b1;
         mio_q <= 1'b0;
         addrIn_q <= '0;
         dataIn_q <= '0;
      end else begin
         smpMeta_q <= {busHoldGrant, wrNIn, rdNIn};
         smpSync_q <= smpMeta_q;
         smpDirect_q <= {busHoldGrant, wrNIn, rdNIn};
         csN_q <= csN;
         mio_q <= memIoSelectIn;
         addrIn_q <= localAddrIn; // RULE1
         dataIn_q <= localDataIn;
      end
   end

   always_ff @(posedge mclk) begin
      if (memWr) begin
         mem_q[memIndex(addrIn_q)] <= dataIn_q; // RULE18
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         slaveEn_q <= 1'b0;
         irq_q <= 1'b0;
         drawPrev_q <= 1'b0;
         dispPrev_q <= 1'b0;
      end else if (inRst) begin
         slaveEn_q <= 1'b0;
         irq_q <= 1'b0;
         drawPrev_q <= 1'b0;
         dispPrev_q <= 1'b0;
      end else begin
         slaveEn_q <= slaveHit; // RULE9
         drawPrev_q <= drawIrq;
         dispPrev_q <= dispIrq;
         // a new engine event beats a clear in the same cycle
         irq_q <= irqEvt ? 1'b1 : (irqClr ? 1'b0 : irq_q); // RULE13
      end
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         M_IDLE: if (engineNeedBus) state_d = M_REQ; // RULE11
         M_REQ: if (grantS) state_d = M_CYCLE; // RULE12
         M_CYCLE: state_d = M_WAIT;
         M_WAIT: if (readyS) state_d = M_RELEASE; // RULE10
         M_RELEASE: state_d = M_IDLE;
         default: state_d = M_IDLE;
      endcase
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_q <= M_IDLE;
         mreq_q <= '0;
         holdReq_q <= 1'b0;
         masterEn_q <= 1'b0;
         busOe_q <= 1'b0;
         rdStrobeN_q <= 1'b1;
         wrStrobeN_q <= 1'b1;
         engDone_q <= 1'b0;
         engRdata_q <= '0;
      end else if (inRst) begin
         state_q <= M_IDLE;
         holdReq_q <= 1'b0;
         masterEn_q <= 1'b0;
         busOe_q <= 1'b0;
         rdStrobeN_q <= 1'b1;
         wrStrobeN_q <= 1'b1;
         engDone_q <= 1'b0;
      end else begin
         engDone_q <= 1'b0;
         if (cycleEn) begin
            state_q <= state_d;
            case (state_q)
               M_IDLE: if (engineNeedBus) begin
                  holdReq_q <= 1'b1; // RULE11
                  mreq_q <= engineReq;
               end
               M_REQ: if (grantS) begin
                  masterEn_q <= 1'b1; // RULE8
                  busOe_q <= 1'b1; // RULE19
               end
               // one flop per strobe keeps the pins free of decode glitches
               M_CYCLE: begin
                  rdStrobeN_q <= mreq_q.write; // RULE4
                  wrStrobeN_q <= !mreq_q.write; // RULE4
               end
               M_WAIT: if (readyS) begin
                  rdStrobeN_q <= 1'b1;
                  wrStrobeN_q <= 1'b1;
                  busOe_q <= 1'b0; // RULE19
                  engDone_q <= 1'b1;
                  engRdata_q <= dataIn_q;
               end
               M_RELEASE: begin
                  masterEn_q <= 1'b0; // RULE8
                  holdReq_q <= 1'b0; // RULE19
               end
               default: holdReq_q <= 1'b0;
            endcase
         end
      end
   end

   // one data driver: slave read data, else master write data
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         dataOe_q <= 1'b0;
         dataOut_q <= '0;
      end else begin
         dataOe_q <= (slaveHit && rdAct) || (busOe_q && mreq_q.write && !inRst); // RULE18
         dataOut_q <= (slaveHit && rdAct) ? slaveRd : mreq_q.wdata;
      end
   end

   assign localAddrOut = mreq_q.addr;
   assign localAddrOe = busOe_q; // RULE1
   assign localDataOut = dataOut_q;
   assign localDataOe = dataOe_q;
   assign upperByteEnableNOut = UBE_MASTER_LEVEL; // RULE2
   assign upperByteEnableNOe = busOe_q; // RULE2
   assign rdNOut = rdStrobeN_q; // RULE4
   assign wrNOut = wrStrobeN_q; // RULE4
   assign rdNOe = busOe_q;
   assign wrNOe = busOe_q;
   assign memIoSelectOut = MIO_MASTER_LEVEL; // RULE5
   assign memIoSelectOe = busOe_q; // RULE5
   assign busHoldRequest = holdReq_q;
   assign masterPathEnable = masterEn_q;
   assign slavePathEnable = slaveEn_q;
   assign irqOut = irq_q;
   assign phaseOne = phase_q;
   assign strapOut = strap_q;
   assign engineDone = engDone_q;
   assign engineRdata = engRdata_q;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   sequence grantTaken;
      state_q == M_REQ && cycleEn && grantS && rstSync_q;
   endsequence
   sequence ownBus;
      masterEn_q && holdReq_q;
   endsequence

   a_grant_enables: assert property (grantTaken |=> ownBus) // RULE8
      else $error("master enable missing after grant");
   a_addr_owner: assert property (localAddrOe |-> ownBus) // RULE1
      else $error("address driven without owning bus");
   a_mio_owner: assert property (memIoSelectOe |-> masterEn_q && holdReq_q) // RULE5
      else $error("mem io driven outside mastership");
   a_slave_idle_bus: assert property (slavePathEnable |-> !localAddrOe && !rdNOe) // RULE9
      else $error("slave cycle while driving bus");
   a_slave_cs: assert property ($rose(slavePathEnable) |-> !$past(csN_q)) // RULE7
      else $error("slave cycle without chip select");
   a_irq_clear: assert property (irqClr && !irqEvt && rstSync_q |=> !irqOut) // RULE13
      else $error("interrupt not cleared");
   a_irq_set: assert property (irqEvt && rstSync_q |=> irqOut) // RULE13
      else $error("interrupt event lost");
   a_phase_align: assert property (!rstSync_q |=> phaseOne) // RULE15
      else $error("divider not at phase one in reset");
   a_phase_toggle: assert property (rstSync_q |=> phaseOne != $past(phaseOne)) // RULE17
      else $error("divider not toggling");
   a_release_order: assert property ($fell(busOe_q) |-> holdReq_q ##1 holdReq_q) // RULE19
      else $error("request dropped before release");
   a_strap_hold: assert property (rstDone_q && $past(rstDone_q) |-> $stable(strap_q)) // RULE3
      else $error("strap changed after reset");
endmodule // host_local_bus_interface

// [hlb_bus_owner_model.sv]
`timescale 1ns/10ps
module hlb_bus_owner_model (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic busHoldRequest,
   input wire logic rdN,
   input wire logic wrN,
   input wire logic [3:0] waitStates,
   input wire logic [15:0] readWord,
   output logic busHoldGrant,
   output logic readyN,
   output logic [15:0] dataOut
);
   logic [3:0] waitCnt_q;
   logic strobeOn;
   assign strobeOn = !rdN || !wrN;
   // stale data is inverted so a late sample never matches
   assign dataOut = rdN ? ~readWord : readWord;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         busHoldGrant <= 1'b0;
         readyN <= 1'b1;
         waitCnt_q <= 4'h0;
      end else begin
         busHoldGrant <= busHoldRequest;
         waitCnt_q <= strobeOn ? waitCnt_q + 4'h1 : 4'h0;
         readyN <= !(strobeOn && waitCnt_q >= waitStates);
      end
   end
endmodule // hlb_bus_owner_model

// [host_local_bus_interface_tb.sv]
`timescale 1ns/10ps
module host_local_bus_interface_tb;
   import hlb_pkg::*;
   logic mclk = 1'b0, resetn = 1'b0, csN = 1'b1, tbUbeN = 1'b1, tbMio = 1'b1;
   logic tbRdN = 1'b1, tbWrN = 1'b1, drawIrq = 1'b0, dispIrq = 1'b0, engineNeedBus = 1'b0;
   logic [ADDR_W-1:0] tbAddr = '0;
   logic [DATA_W-1:0] tbData = '0, readWord = 16'hC35A;
   logic [3:0] waitStates = 4'h0;
   hlb_mreq_t engineReq = '0;
   logic [ADDR_W-1:0] aOut, aPin;
   logic [DATA_W-1:0] dOut, dPin, mData, engineRdata;
   logic aOe, dOe, uOut, uOe, uPin, rOut, rOe, rPin, wOut, wOe, wPin, mOut, mOe, mPin;
   logic readyN, grant, bus_hold_request, menOut, senOut, irqOut, phaseOne, engineDone;
   hlb_strap_t strap;
   int n_mismatch = 0, cmp_count = 0, cycles = 0;
   assign aPin = aOe ? aOut : tbAddr;
   assign dPin = dOe ? dOut : (rOe ? mData : tbData);
   assign uPin = uOe ? uOut : tbUbeN;
   assign rPin = rOe ? rOut : tbRdN;
   assign wPin = wOe ? wOut : tbWrN;
   assign mPin = mOe ? mOut : tbMio;
   host_local_bus_interface i_dut (.mclk(mclk), .resetn(resetn), .localAddrIn(aPin),
      .localAddrOut(aOut), .localAddrOe(aOe), .localDataIn(dPin), .localDataOut(dOut),
      .localDataOe(dOe), .upperByteEnableNIn(uPin), .upperByteEnableNOut(uOut),
      .upperByteEnableNOe(uOe), .rdNIn(rPin), .rdNOut(rOut), .rdNOe(rOe), .wrNIn(wPin),
      .wrNOut(wOut), .wrNOe(wOe), .memIoSelectIn(mPin), .memIoSelectOut(mOut),
      .memIoSelectOe(mOe), .csN(csN), .readyN(readyN), .busHoldGrant(grant),
      .busHoldRequest(bus_hold_request), .masterPathEnable(menOut), .slavePathEnable(senOut),
      .drawIrq(drawIrq), .dispIrq(dispIrq), .irqOut(irqOut), .phaseOne(phaseOne),
      .strapOut(strap), .engineNeedBus(engineNeedBus), .engineReq(engineReq),
      .engineDone(engineDone), .engineRdata(engineRdata));
   hlb_bus_owner_model i_owner (.mclk(mclk), .resetn(resetn), .busHoldRequest(bus_hold_request),
      .rdN(rPin), .wrN(wPin), .waitStates(waitStates), .readWord(readWord),
      .busHoldGrant(grant), .readyN(readyN), .dataOut(mData));
   always #(CLK_PERIOD_NS / 2.0) mclk = ~mclk;
   task automatic chk(input logic [31:0] act, input logic [31:0] exp);
      cmp_count++;
      if (act !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %0h expected %0h", $time, act, exp);
      end
   endtask
   task automatic do_reset(input logic u, input logic m, input logic r, input logic w);
      @(posedge mclk);
      resetn <= 1'b0;
      {tbUbeN, tbMio, tbRdN, tbWrN} <= {u, m, r, w};
      repeat (10) @(posedge mclk);
      #1 chk({irqOut, bus_hold_request, menOut, senOut, aOe, phaseOne}, 6'h01);
      @(posedge mclk);
      resetn <= 1'b1;
      repeat (4) @(posedge mclk);
      #1 chk({strap, phaseOne}, {u == 1'b1, m == 1'b0, r, w, 1'b1});
      @(posedge mclk);
      {tbUbeN, tbMio, tbRdN, tbWrN} <= 4'hF;
      #1 chk(phaseOne, 1'b0);
      $display("test reset done");
   endtask
   task automatic sacc(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
         input logic m, output logic [DATA_W-1:0] q);
      @(posedge mclk);
      {tbAddr, tbData, tbMio, csN} <= {a, d, m, 1'b0};
      if (wr) tbWrN <= 1'b0;
      else tbRdN <= 1'b0;
      for (int i = 0; i < 12 && senOut !== 1'b1; i++) begin
         @(posedge mclk);
         #1;
      end
      chk({senOut, aOe, !wr && dOe !== 1'b1}, 3'h4);
      q = dOut;
      @(posedge mclk);
      {csN, tbRdN, tbWrN, tbData} <= {3'h7, ~d};
      repeat (3) @(posedge mclk);
   endtask
   task automatic t_slave;
      logic [DATA_W-1:0] q;
      sacc(1'b1, 22'h000002, 16'hA5C3, 1'b1, q);
      sacc(1'b1, 22'h00001E, 16'h5A3C, 1'b1, q);
      // strobe without chip select must leave the array alone
      @(posedge mclk);
      {tbAddr, tbData, tbWrN} <= {22'h000002, 16'hFFFF, 1'b0};
      repeat (6) begin
         @(posedge mclk);
         #1 chk(senOut, 1'b0);
      end
      @(posedge mclk);
      tbWrN <= 1'b1;
      sacc(1'b0, 22'h000002, 16'h0000, 1'b1, q);
      chk(q, 16'hA5C3);
      sacc(1'b0, 22'h00001E, 16'h0000, 1'b1, q);
      chk(q, 16'h5A3C);
      $display("test slave done");
   endtask
   task automatic t_irq;
      logic [DATA_W-1:0] q;
      @(posedge mclk);
      drawIrq <= 1'b1;
      repeat (4) @(posedge mclk);
      #1 chk(irqOut, 1'b1);
      sacc(1'b0, IRQ_REG_ADDR, 16'h0000, 1'b0, q);
      #1 chk({q[0], irqOut}, 2'h2);
      @(posedge mclk);
      dispIrq <= 1'b1;
      repeat (4) @(posedge mclk);
      #1 chk(irqOut, 1'b1);
      sacc(1'b1, IRQ_REG_ADDR, 16'h0000, 1'b0, q);
      {drawIrq, dispIrq} <= 2'h0;
      #1 chk(irqOut, 1'b0);
      $display("test irq done");
   endtask
   task automatic mx(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
         input logic [3:0] ws);
      logic seen;
      seen = 1'b0;
      @(posedge mclk);
      {engineReq, engineNeedBus, waitStates} <= {a, d, wr, 1'b1, ws};
      for (int i = 0; i < 80 && engineDone !== 1'b1; i++) begin
         @(posedge mclk);
         #1;
         if (aOe === 1'b1) chk({menOut, grant, aOut}, {2'h3, a});
         if (menOut === 1'b1 && !seen) begin
            seen = 1'b1;
            chk({bus_hold_request, uOe, uOut, mOe, mOut}, 5'h1B);
         end
         if (wOe === 1'b1 && wOut === 1'b0) chk({dOe, dOut}, {1'b1, d});
      end
      chk({seen, engineDone}, 2'h3);
      if (!wr) chk(engineRdata, readWord);
      @(posedge mclk);
      engineNeedBus <= 1'b0;
      repeat (6) @(posedge mclk);
      #1 chk({bus_hold_request, menOut, aOe, rOe, wOe}, 5'h00);
      $display("test master done");
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // ceiling well above the few hundred cycles the sequence needs
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         $display("mismatch at %0t: got %0h expected %0h", $time, cycles, 0);
         complete_run;
      end
   end
   initial begin
      do_reset(1'b1, 1'b0, 1'b1, 1'b0);
      t_slave;
      t_irq;
      mx(1'b1, 22'h012346, 16'h1234, 4'h0);
      mx(1'b0, 22'h2ABCD0, 16'h0000, 4'h5);
      // second strap set: asynchronous strobes, older protocol
      do_reset(1'b0, 1'b1, 1'b0, 1'b1);
      t_slave;
      // older protocol matches the interrupt register by address alone
      t_irq;
      mx(1'b0, 22'h000100, 16'h0000, 4'h2);
      complete_run;
   end
endmodule // host_local_bus_interface_tb
